// ### rtl/temp_channel_control_limits.sv
// Temperature channel control, over-temperature limit and parameter port
//
// Register access over APB was left to the implementer.
`default_nettype none
`include "temp_chan_consts.svh"
module temp_channel_control_limits
  import temp_chan_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Converter side
  input  wire logic        conv_done,
  input  wire logic [7:0]  conv_result,
  output var  logic        measure_remote,
  // Events
  output var  logic        overtemp_output,
  output var  logic        overtemp_irq,
  output var  logic        data_valid_irq
);

  state_s      r;
  state_s      n;
  logic        mem_we;
  logic [15:0] mem_rdata;
  logic        wr;
  logic        conv_evt;
  logic [31:0] rd_mux;
  logic        hit;

  // Byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'b00};
  endfunction : reg_addr

  // Read view of the channel control register
  function automatic logic [7:0] tctl_view(input state_s s);
    logic [4:0] sel;
    sel = (s.meas_remote && s.last_remote) ? `SEL_REMOTE : `SEL_LOCAL;
    tctl_view = {s.data_valid, s.meas_remote, s.dv_irq_en, sel};
  endfunction : tctl_view

  // Parameter registers, addressed by the index register
  param_mem u_param_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .addr    (r.pindex),
    .wr_en   (mem_we),
    .wdata   (pwdata[15:0]),
    .rdata   (mem_rdata)
  );

  // Address decode and read data
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      reg_addr(`IDX_CONFIG): rd_mux = {29'h0, r.ot_irq_en, r.remote_en, r.conv_en};
      reg_addr(`IDX_STATUS): rd_mux = {31'h0, r.ot_event};
      reg_addr(`IDX_LIMIT):  rd_mux = {24'h0, r.limit};
      reg_addr(`IDX_PINDEX): rd_mux = {24'h0, r.pindex};
      reg_addr(`IDX_PDATA):  rd_mux = {16'h0, mem_rdata};
      reg_addr(`IDX_TCTL):   rd_mux = {24'h0, tctl_view(r)};
      reg_addr(`IDX_TDATA):  rd_mux = {24'h0, r.temp_data};
      default: begin
        hit    = 1'b0;
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Write strobe in the ready cycle, accepted conversion pulse
  assign wr       = r.pready && psel && penable && pwrite && hit;
  assign conv_evt = conv_done && r.conv_en;

  // Next state
  always_comb begin
    n      = r;
    mem_we = 1'b0;
    // Bus phases: setup, one wait cycle, ready
    case (r.phase)
      PH_IDLE: begin
        if (psel && !penable) begin
          n.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        n.phase   = PH_DONE;
        n.pready  = 1'b1;
        n.prdata  = rd_mux;
        n.pslverr = !hit;
      end
      PH_DONE: begin
        n.phase   = PH_IDLE;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
      end
      default: begin
        n.phase  = PH_IDLE;
        n.pready = 1'b0;
      end
    endcase
    // Software writes
    if (wr) begin
      case (paddr)
        reg_addr(`IDX_CONFIG): begin
          n.conv_en   = pwdata[`CFG_CONV_EN];
          n.remote_en = pwdata[`CFG_REMOTE_EN];
          n.ot_irq_en = pwdata[`CFG_OT_IRQ_EN];
        end
        reg_addr(`IDX_STATUS): begin
          if (pwdata[`STAT_OT_EVENT]) begin
            n.ot_event = 1'b0;
          end
        end
        reg_addr(`IDX_LIMIT):  n.limit  = pwdata[7:0];
        reg_addr(`IDX_PINDEX): n.pindex = pwdata[7:0];
        reg_addr(`IDX_PDATA): begin
          if (!r.locked) begin
            mem_we = 1'b1;
            if (r.pindex == `LOCK_INDEX && pwdata[15:0] == `LOCK_VALUE) begin
              n.locked = 1'b1;
            end
          end
        end
        reg_addr(`IDX_TCTL): begin
          n.dv_irq_en   = pwdata[`TCTL_DV_IRQ_EN];
          n.meas_remote = pwdata[`TCTL_REM_MEAS];
          if (pwdata[`TCTL_DATA_VALID]) begin
            n.data_valid = 1'b0;
          end
        end
        default: n.limit = r.limit;
      endcase
    end
    // Remote measurement needs the remote diode enabled
    if (!n.remote_en) begin
      n.meas_remote = 1'b0;
    end
    // End of conversion: capture, flag, compare, pick next input
    if (conv_evt) begin
      n.temp_data   = conv_result;
      n.last_remote = r.next_remote;
      n.data_valid  = 1'b1;
      if (!r.next_remote && ($signed(conv_result) > $signed(r.limit))) begin
        n.ot_event = 1'b1;
      end
      n.next_remote = r.meas_remote && !r.next_remote;
    end
    if (!n.meas_remote) begin
      n.next_remote = 1'b0;
    end
    // Converter disabled clears the data flag
    if (!n.conv_en) begin
      n.data_valid = 1'b0;
    end
    // Registered outputs
    n.ot_out = n.ot_event;
    n.ot_irq = n.ot_event && n.ot_irq_en;
    n.dv_irq = n.data_valid && n.dv_irq_en;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{phase: PH_IDLE, limit: `LIMIT_RESET, pindex: `PINDEX_RESET, default: '0};
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state
  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign measure_remote  = r.next_remote;
  assign overtemp_output = r.ot_out;
  assign overtemp_irq    = r.ot_irq;
  assign data_valid_irq  = r.dv_irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence local_over_s;
    conv_evt && !r.next_remote && ($signed(conv_result) > $signed(r.limit));
  endsequence

  sequence local_not_over_s;
    conv_evt && !r.next_remote && ($signed(conv_result) <= $signed(r.limit)) && !r.ot_event;
  endsequence

  sequence lock_write_s;
    wr && paddr == reg_addr(`IDX_PDATA) && r.pindex == `LOCK_INDEX && pwdata[15:0] == `LOCK_VALUE;
  endsequence

  sequence setup_s;
    r.phase == PH_IDLE && psel && !penable;
  endsequence

  sequence remote_result_s;
    conv_evt && r.next_remote && !r.ot_event;
  endsequence

  sequence unmapped_s;
    r.phase == PH_WAIT && !hit;
  endsequence

  sequence tctl_remote_s;
    r.phase == PH_WAIT && paddr == reg_addr(`IDX_TCTL) && r.meas_remote && r.last_remote;
  endsequence

  sequence dv_w1c_s;
    wr && paddr == reg_addr(`IDX_TCTL) && pwdata[`TCTL_DATA_VALID] && !conv_evt;
  endsequence

  sequence dv_w0_s;
    wr && paddr == reg_addr(`IDX_TCTL) && !pwdata[`TCTL_DATA_VALID] && r.data_valid && n.conv_en;
  endsequence

  // Over-temperature, parameter lock, bus timing, select field, remote forcing and data-valid checks
  ot_event_set_a: assert property (local_over_s |=> r.ot_event && overtemp_output)
    else $error("over-temperature not flagged");
  ot_equal_quiet_a: assert property (local_not_over_s |=> !r.ot_event)
    else $error("event raised without exceeding limit");
  ot_irq_gate_a: assert property (!r.ot_irq_en && !n.ot_irq_en |=> !overtemp_irq)
    else $error("over-temperature interrupt while disabled");
  lock_takes_a: assert property (lock_write_s |=> r.locked ##1 (r.locked && !mem_we))
    else $error("parameter lock failed");
  setup_wait_a: assert property (setup_s |=> !pready ##1 pready ##1 !pready)
    else $error("bus answer timing wrong");
  sel_local_a: assert property (r.phase == PH_WAIT && paddr == reg_addr(`IDX_TCTL) && !r.meas_remote
                                |=> prdata[4:0] == `SEL_LOCAL)
    else $error("select field not 16 with remote off");
  remote_forced_a: assert property (!r.remote_en |-> !r.meas_remote && !measure_remote)
    else $error("remote measurement without remote diode");
  alternate_a: assert property (conv_evt && r.meas_remote && n.meas_remote
                                |=> measure_remote != $past(measure_remote))
    else $error("diodes did not alternate");
  dv_set_a: assert property (conv_evt && n.conv_en |=> r.data_valid)
    else $error("data valid not set at conversion end");
  dv_off_a: assert property (!r.conv_en |-> !r.data_valid)
    else $error("data valid set while converter off");
  dv_irq_a: assert property (r.data_valid && r.dv_irq_en && n.data_valid && n.dv_irq_en
                             |=> data_valid_irq)
    else $error("data valid interrupt missing");

  // Flag to output and interrupt relations
  ot_out_follow_a: assert property (overtemp_output == r.ot_event)
    else $error("over-temperature output differs from event flag");
  ot_irq_on_a: assert property (r.ot_event && r.ot_irq_en |-> overtemp_irq)
    else $error("over-temperature interrupt missing");
  remote_no_event_a: assert property (remote_result_s |=> !r.ot_event)
    else $error("remote result raised over-temperature event");

  // Register writes and the parameter lock
  limit_write_a: assert property (wr && paddr == reg_addr(`IDX_LIMIT)
                                  |=> r.limit == $past(pwdata[7:0]))
    else $error("limit write not stored");
  index_write_a: assert property (wr && paddr == reg_addr(`IDX_PINDEX)
                                  |=> r.pindex == $past(pwdata[7:0]))
    else $error("index write not stored");
  lock_hold_a: assert property (r.locked |=> r.locked && !mem_we)
    else $error("parameter lock released or bypassed");

  // Bus answer shape
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  unmapped_err_a: assert property (unmapped_s |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Select field, local-only mode and data-valid handling
  sel_remote_a: assert property (tctl_remote_s |=> prdata[4:0] == `SEL_REMOTE)
    else $error("select field not 15 after remote result");
  local_only_a: assert property (conv_evt && !r.meas_remote |=> !measure_remote)
    else $error("remote picked in local-only mode");
  dv_clear_a: assert property (dv_w1c_s |=> !r.data_valid)
    else $error("data valid not cleared by write one");
  dv_keep_a: assert property (dv_w0_s |=> r.data_valid)
    else $error("data valid cleared by write zero");
  dv_irq_off_a: assert property (!r.dv_irq_en |-> !data_valid_irq)
    else $error("data valid interrupt while disabled");

endmodule : temp_channel_control_limits
`default_nettype wire

// ### rtl/temp_chan_consts.svh
// Register indices, field positions and reset values of the temperature channel block
`ifndef TEMP_CHAN_CONSTS_SVH
`define TEMP_CHAN_CONSTS_SVH

// Register indices, byte address is four times the index
`define IDX_CONFIG      16'hFF20
`define IDX_STATUS      16'hFF22
`define IDX_LIMIT       16'hFF28
`define IDX_PINDEX      16'hFF2A
`define IDX_PDATA       16'hFF2C
`define IDX_TCTL        16'hFF30
`define IDX_TDATA       16'hFF32

// Reset values
`define LIMIT_RESET     8'h7F
`define PINDEX_RESET    8'h00

// Converter configuration bits
`define CFG_CONV_EN     0
`define CFG_REMOTE_EN   1
`define CFG_OT_IRQ_EN   2

// Status bits
`define STAT_OT_EVENT   0

// Temperature channel control bits
`define TCTL_DV_IRQ_EN  5
`define TCTL_REM_MEAS   6
`define TCTL_DATA_VALID 7

// Input select codes
`define SEL_REMOTE      5'h0F
`define SEL_LOCAL       5'h10

// Parameter lock write
`define LOCK_INDEX      8'h00
`define LOCK_VALUE      16'h0001
`define PARAM_DEPTH     256

`endif

// ### rtl/temp_chan_pkg.sv
// Types shared by the temperature channel block
`default_nettype none
package temp_chan_pkg;

  // Bus transfer phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_DONE
  } bus_phase_e;

  // Whole state of the control block
  typedef struct packed {
    bus_phase_e  phase;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  limit;
    logic [7:0]  pindex;
    logic        locked;
    logic        conv_en;
    logic        remote_en;
    logic        ot_irq_en;
    logic        dv_irq_en;
    logic        meas_remote;
    logic        data_valid;
    logic        last_remote;
    logic        next_remote;
    logic [7:0]  temp_data;
    logic        ot_event;
    logic        ot_out;
    logic        ot_irq;
    logic        dv_irq;
  } state_s;

endpackage : temp_chan_pkg
`default_nettype wire

// ### rtl/param_mem.sv
// Parameter register memory with registered read data
`default_nettype none
module param_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Access
  input  wire logic [7:0]  addr,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  output var  logic [15:0] rdata
);

  logic [15:0] mem [0:255];

  // Array write, no reset on contents
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read of the addressed word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule : param_mem
`default_nettype wire

// ### testbench/temp_channel_control_limits_tb.sv
// Self-checking bench for the temperature channel control and limit block
`default_nettype none
`include "temp_chan_consts.svh"
module temp_channel_control_limits_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Byte addresses, four times each register index
  localparam logic [31:0] A_CFG  = 32'(`IDX_CONFIG) << 2;
  localparam logic [31:0] A_STAT = 32'(`IDX_STATUS) << 2;
  localparam logic [31:0] A_LIM  = 32'(`IDX_LIMIT) << 2;
  localparam logic [31:0] A_PIX  = 32'(`IDX_PINDEX) << 2;
  localparam logic [31:0] A_PDAT = 32'(`IDX_PDATA) << 2;
  localparam logic [31:0] A_TCTL = 32'(`IDX_TCTL) << 2;
  localparam logic [31:0] A_TDAT = 32'(`IDX_TDATA) << 2;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_done = 1'b0;
  logic [7:0]  conv_result = '0;
  logic        measure_remote;
  logic        overtemp_output;
  logic        overtemp_irq;
  logic        data_valid_irq;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        err;

  // Device under test
  temp_channel_control_limits u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_result(conv_result), .measure_remote(measure_remote),
    .overtemp_output(overtemp_output), .overtemp_irq(overtemp_irq), .data_valid_irq(data_valid_irq)
  );

  // Clock and hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2); // One wait state before the answer
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let registered outputs settle
  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // One conversion result pulse
  task automatic conv(input logic [7:0] res);
    @(posedge pclk);
    conv_done <= 1'b1; conv_result <= res;
    @(posedge pclk);
    conv_done <= 1'b0;
    settle();
  endtask : conv

  // Reset values and an unmapped access
  task automatic test_reset();
    apb(1'b0, A_LIM, 32'h0);
    chk(rd, 32'h7F);
    apb(1'b0, A_PIX, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, A_TCTL, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 32'h10, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask : test_reset

  // Indexed parameter port and write-once lock
  task automatic test_params();
    apb(1'b1, A_PIX, 32'h05);
    apb(1'b0, A_PIX, 32'h0);
    chk(rd, 32'h05);
    apb(1'b1, A_PDAT, 32'hABCD);
    apb(1'b0, A_PDAT, 32'h0);
    chk(rd, 32'hABCD);
    apb(1'b1, A_PIX, 32'h06);
    apb(1'b1, A_PDAT, 32'h1111);
    apb(1'b0, A_PDAT, 32'h0);
    chk(rd, 32'h1111);
    apb(1'b1, A_PIX, 32'h05);
    apb(1'b0, A_PDAT, 32'h0);
    chk(rd, 32'hABCD);
    apb(1'b1, A_PIX, 32'h00);
    apb(1'b1, A_PDAT, 32'h0001);
    apb(1'b0, A_PDAT, 32'h0);
    chk(rd, 32'h0001);
    apb(1'b1, A_PIX, 32'h05);
    apb(1'b1, A_PDAT, 32'h1234);
    chk(32'(err), 32'h0);
    apb(1'b0, A_PDAT, 32'h0);
    chk(rd, 32'hABCD);
  endtask : test_params

  // Signed limit compare and interrupt gating
  task automatic test_overtemp();
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b1, A_LIM, 32'h02);
    apb(1'b0, A_LIM, 32'h0);
    chk(rd, 32'h02);
    conv(8'h80);
    chk(32'(overtemp_output), 32'h0);
    conv(8'h02);
    chk(32'(overtemp_output), 32'h0);
    conv(8'h03);
    chk(32'(overtemp_output), 32'h1);
    chk(32'(overtemp_irq), 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(1'b1, A_CFG, 32'h5);
    settle();
    chk(32'(overtemp_irq), 32'h1);
    apb(1'b1, A_STAT, 32'h1);
    settle();
    chk(32'(overtemp_output), 32'h0);
    chk(32'(overtemp_irq), 32'h0);
    apb(1'b1, A_LIM, 32'hFE);
    conv(8'h05);
    chk(32'(overtemp_output), 32'h1);
    apb(1'b1, A_STAT, 32'h1);
    apb(1'b1, A_LIM, 32'h02);
  endtask : test_overtemp

  // Data-valid flag, its interrupt, data read and clearing
  task automatic test_valid();
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7:0]), 32'h90);
    chk(32'(data_valid_irq), 32'h0);
    apb(1'b1, A_TCTL, 32'h20);
    settle();
    chk(32'(data_valid_irq), 32'h1);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7:0]), 32'hB0);
    apb(1'b1, A_TCTL, 32'hA0);
    settle();
    chk(32'(data_valid_irq), 32'h0);
    conv(8'hA5);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7]), 32'h1);
    chk(32'(data_valid_irq), 32'h1);
    apb(1'b0, A_TDAT, 32'h0);
    chk(rd, 32'hA5);
    apb(1'b1, A_TCTL, 32'hA0);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7:0]), 32'h30);
    conv(8'h00);
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7]), 32'h0);
    chk(32'(data_valid_irq), 32'h0);
  endtask : test_valid

  // Remote measurement forcing and alternation
  task automatic test_remote();
    apb(1'b1, A_TCTL, 32'h40);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[6:0]), 32'h10);
    apb(1'b1, A_CFG, 32'h3);
    apb(1'b1, A_TCTL, 32'h40);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[6]), 32'h1);
    settle();
    chk(32'(measure_remote), 32'h0);
    conv(8'h01);
    chk(32'(measure_remote), 32'h1);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[4:0]), 32'h10);
    conv(8'h11);
    chk(32'(measure_remote), 32'h0);
    chk(32'(overtemp_output), 32'h0);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7:0]), 32'hCF);
    apb(1'b1, A_TCTL, 32'hC0);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[7:0]), 32'h4F);
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b0, A_TCTL, 32'h0);
    chk(32'(rd[6:0]), 32'h10);
    chk(32'(measure_remote), 32'h0);
  endtask : test_remote

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_params();
    test_overtemp();
    test_valid();
    test_remote();
    tally_and_finish();
  end
endmodule : temp_channel_control_limits_tb
`default_nettype wire
